/* logic/bus_terminal_host_map.vh */
// Register offsets, field positions and timing constants of the host register bank.
`ifndef BUS_TERMINAL_HOST_MAP_VH
`define BUS_TERMINAL_HOST_MAP_VH
// ****************************************************************
// Register offsets on the five-bit register address.
// ****************************************************************
`define OFF_INT_MASK      5'h00
`define OFF_CFG_PRI       5'h01
`define OFF_CFG_SEC       5'h02
`define OFF_DATA_STACK    5'h0A
`define OFF_FRAME_LEFT    5'h0B
`define OFF_MSG_LEFT      5'h0C
`define OFF_FRAME_SHARED  5'h0D
`define OFF_STATUS_WORD   5'h0E
`define OFF_BIT_WORD      5'h0F
// ****************************************************************
// Reset values and write masks.
// ****************************************************************
`define RST_INT_MASK      16'h0000
`define RST_CFG_PRI       16'h0000
`define RST_CFG_SEC       16'h0000
`define RST_FRAME_SHARED  16'h0000
`define INT_MASK_WMASK    16'h7FFF
// ****************************************************************
// Field positions.
// ****************************************************************
`define CP_ROLE_HI        15
`define CP_ROLE_LO        14
`define CP_AREA           13
`define CP_MMT            12
`define CP_TRIG_EN        11
`define CP_START_TRIG     10
`define CP_STOP_TRIG      9
`define CP_EXT_TRIG       7
`define CP_RO_HI          2
`define CS_ENH_INT        15
`define CS_PARITY_EN      14
`define CS_TTR_HI         9
`define CS_TTR_LO         7
`define CS_SYNC_CLR       6
`define CS_SYNC_LOAD      5
`define CS_AUTO_CLR       4
`define CS_LEVEL_PULSE    3
`define INT_MODE_EVENT    1
// ****************************************************************
// Roles on configuration bits 15..14.
// ****************************************************************
`define ROLE_BC           2'b00
`define ROLE_RT           2'b10
`define ROLE_MT           2'b01
// ****************************************************************
// Timing: resolution figures in microseconds and the clock period in ns.
// ****************************************************************
`define CLK_PERIOD_NS     10
`define FRAME_LSB_US      100
`define MSG_LSB_US        1
`define TAG_BASE_US       2
`define FRAME_LSB_CYC     ((`FRAME_LSB_US * 1000) / `CLK_PERIOD_NS)
`define MSG_LSB_CYC       ((`MSG_LSB_US * 1000) / `CLK_PERIOD_NS)
`define TAG_BASE_CYC      ((`TAG_BASE_US * 1000) / `CLK_PERIOD_NS)
`endif

/* logic/tick_divider.v */
// Divider that gives a one-cycle enable pulse every PERIOD cycles.
`timescale 1ns/1ps
module tick_divider #(
   parameter integer PERIOD = 100
) (
   input  wire        i_clk,
   input  wire        i_rst_n,
   input  wire        i_restart,
   output wire        o_tick
);
   reg  [15:0] cnt_ff;
   // ****************************************************************
   // Counter
   // ****************************************************************
   // Restart realigns the phase so the first period after a load is whole.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= 16'h0000;
      end else if (i_restart || cnt_ff == PERIOD[15:0] - 16'h0001) begin
         cnt_ff <= 16'h0000;
      end else begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end
   assign o_tick = !i_restart && (cnt_ff == PERIOD[15:0] - 16'h0001);
endmodule // tick_divider

/* logic/bus_terminal_host_registers.v */
// Host register bank of a 1553 bus controller, remote terminal and monitor.
// Notes on behaviour
// - Readable monitor data stack pointer in shared RAM.
// - Read-only frame time left, 100 us LSB.
// - Read-only time to next message, 1 us.
// - BC mode: shared register holds frame period.
// - RT mode: shared register loads last command.
// - Monitor: 16-bit trigger word starts, stops, interrupts.
// - Status and test words read-only; writes ignored.
// - Interrupt mask bits 14..0; bit 15 reserved.
// - Interrupt bit 1 event depends on role.
// - Secondary config bits 9..7 select tag resolution.
// - Tag 2..64 us per count, or external clock.
// - Sync clears tag; sync-with-data loads tag.
// - Bit 4 auto-clear; bit 3 level or pulse.
// - Secondary config holds terminal memory options.
// - Enhanced interrupts, parity enable, service request clear.
// - BC bits 2..0 read-only enabled, frame, message.
// - RT bits 11..7 status flags; bit 0 in-progress.
// - Alternate status: bits 11..1 supply status bits.
// - Monitor trigger controls; bits 2..0 read-only state.
// - Bit 12 monitor enable; bit 13 area select.
`timescale 1ns/1ps
`include "bus_terminal_host_map.vh"
module bus_terminal_host_registers (
   input  wire        i_clk,
   input  wire        i_rst_n,
   // Register port.
   input  wire [4:0]  i_addr,
   input  wire        i_wr,
   input  wire        i_rd,
   input  wire [15:0] i_wdata,
   output reg  [15:0] o_rdata,
   // Protocol engine state fed in on the same clock, except the external tag clock pin.
   input  wire        i_alt_status_en,
   input  wire        i_eng_enabled,
   input  wire        i_frame_active,
   input  wire        i_msg_active,
   input  wire        i_frame_start,
   input  wire        i_msg_gap_load,
   input  wire [15:0] i_msg_gap_us,
   input  wire        i_cmd_valid,
   input  wire [15:0] i_cmd_word,
   input  wire        i_stack_store,
   input  wire        i_stack_load,
   input  wire [15:0] i_stack_base,
   input  wire [15:0] i_status_word,
   input  wire [15:0] i_bit_word,
   input  wire        i_sync,
   input  wire        i_sync_data,
   input  wire [15:0] i_sync_word,
   input  wire        i_mon_word_valid,
   input  wire [15:0] i_mon_word,
   input  wire        i_tag_ext_clk,
   // Decoded results for the protocol engine.
   output wire [1:0]  o_role,
   output wire        o_frame_done,
   output wire        o_msg_due,
   output reg         o_mon_triggered,
   output reg         o_mon_active,
   output wire        o_trigger_event,
   output wire [15:0] o_time_tag,
   output wire [4:0]  o_status_flags,
   output wire [10:0] o_alt_status,
   output wire        o_area_b,
   output wire        o_msg_monitor_en,
   output wire [14:0] o_int_enable,
   output wire [15:0] o_cfg_secondary,
   output wire [11:0] o_bc_controls
);
   reg  [15:0] int_mask_ff;
   reg  [15:0] cfg_pri_ff;
   reg  [15:0] cfg_sec_ff;
   reg  [15:0] shared_ff;
   reg  [15:0] frame_left_ff;
   reg  [15:0] msg_left_ff;
   reg  [15:0] stack_ptr_ff;
   reg  [15:0] tag_ff;
   reg  [5:0]  tag_pre_ff;
   reg         ext_s1_ff;
   reg         ext_s2_ff;
   reg         ext_s3_ff;
   reg  [15:0] nxt_cfg_pri;
   reg  [15:0] ro_bits;
   reg  [5:0]  tag_span;
   wire        frame_tick;
   wire        msg_tick;
   wire        base_tick;
   wire        ext_rise;
   wire        tag_tick;
   wire [2:0]  tag_res;
   wire        is_bc;
   wire        is_rt;
   wire        is_mt;

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Address match used by every write port of the bank.
   function wr_hit;
      input [4:0] addr;
      input [4:0] off;
      input       wr;
      begin
         wr_hit = wr && (addr == off);
      end
   endfunction

   // Counter that decrements to zero and holds there.
   function [15:0] dec_sat;
      input [15:0] val;
      begin
         dec_sat = (val == 16'h0000) ? 16'h0000 : val - 16'h0001;
      end
   endfunction

   assign o_role = cfg_pri_ff[`CP_ROLE_HI:`CP_ROLE_LO];
   assign is_bc  = (o_role == `ROLE_BC);
   assign is_rt  = (o_role == `ROLE_RT);
   assign is_mt  = (o_role == `ROLE_MT);

   // ****************************************************************
   // Rate dividers
   // ****************************************************************
   tick_divider #(.PERIOD(`FRAME_LSB_CYC)) u_frame_div (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_restart (i_frame_start),
      .o_tick    (frame_tick)
   );
   tick_divider #(.PERIOD(`MSG_LSB_CYC)) u_msg_div (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_restart (i_msg_gap_load),
      .o_tick    (msg_tick)
   );
   tick_divider #(.PERIOD(`TAG_BASE_CYC)) u_tag_div (
      .i_clk     (i_clk),
      .i_rst_n   (i_rst_n),
      .i_restart (1'b0),
      .o_tick    (base_tick)
   );

   // ****************************************************************
   // Host writable registers
   // ****************************************************************
   // Read-only state bits in the primary config are never stored, so a host
   // write to them cannot leave a stale value behind the live indication.
   always @* begin
      nxt_cfg_pri = cfg_pri_ff;
      if (wr_hit(i_addr, `OFF_CFG_PRI, i_wr)) begin
         nxt_cfg_pri = i_wdata;
         if (i_wdata[15:14] != `ROLE_RT || !i_alt_status_en) begin
            nxt_cfg_pri[`CP_RO_HI:0] = 3'b000;
         end else begin
            nxt_cfg_pri[0] = 1'b0;
         end
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         int_mask_ff <= `RST_INT_MASK;
         cfg_pri_ff  <= `RST_CFG_PRI;
         cfg_sec_ff  <= `RST_CFG_SEC;
      end else begin
         cfg_pri_ff <= nxt_cfg_pri;
         if (wr_hit(i_addr, `OFF_INT_MASK, i_wr)) begin
            int_mask_ff <= i_wdata & `INT_MASK_WMASK;
         end
         if (wr_hit(i_addr, `OFF_CFG_SEC, i_wr)) begin
            cfg_sec_ff <= i_wdata;
         end
      end
   end

   // ****************************************************************
   // Shared frame period, last command and trigger word
   // ****************************************************************
   // In RT mode a command from the bus wins over a host write that lands in
   // the same cycle, since the register must show the last processed command.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shared_ff <= `RST_FRAME_SHARED;
      end else if (is_rt && i_cmd_valid) begin
         shared_ff <= i_cmd_word;
      end else if (wr_hit(i_addr, `OFF_FRAME_SHARED, i_wr)) begin
         shared_ff <= i_wdata;
      end
   end

   // ****************************************************************
   // Frame and message time remaining
   // ****************************************************************
   // The frame count reloads from the programmed period at each frame start in BC mode.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         frame_left_ff <= 16'h0000;
         msg_left_ff   <= 16'h0000;
      end else begin
         if (i_frame_start && is_bc) begin
            frame_left_ff <= shared_ff;
         end else if (frame_tick) begin
            frame_left_ff <= dec_sat(frame_left_ff);
         end
         if (i_msg_gap_load) begin
            msg_left_ff <= i_msg_gap_us;
         end else if (msg_tick) begin
            msg_left_ff <= dec_sat(msg_left_ff);
         end
      end
   end
   assign o_frame_done = is_bc && i_frame_active && (frame_left_ff == 16'h0000);
   assign o_msg_due    = is_bc && (msg_left_ff == 16'h0000);

   // ****************************************************************
   // Monitor data stack pointer and trigger
   // ****************************************************************
   assign o_trigger_event = is_mt && cfg_pri_ff[`CP_TRIG_EN] && i_mon_word_valid
                            && (i_mon_word == shared_ff);

   // Start-on-trigger arms the monitor; stop-on-trigger halts it.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stack_ptr_ff    <= 16'h0000;
         o_mon_triggered <= 1'b0;
         o_mon_active    <= 1'b0;
      end else begin
         if (i_stack_load) begin
            stack_ptr_ff <= i_stack_base;
         end else if (i_stack_store && o_mon_active) begin
            stack_ptr_ff <= stack_ptr_ff + 16'h0001;
         end
         if (!is_mt || !i_eng_enabled) begin
            o_mon_triggered <= 1'b0;
            o_mon_active    <= 1'b0;
         end else if (o_trigger_event) begin
            o_mon_triggered <= 1'b1;
            if (cfg_pri_ff[`CP_STOP_TRIG] && o_mon_active) begin
               o_mon_active <= 1'b0;
            end else if (cfg_pri_ff[`CP_START_TRIG]) begin
               o_mon_active <= 1'b1;
            end
         end else if (!cfg_pri_ff[`CP_START_TRIG] && !o_mon_triggered) begin
            o_mon_active <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Time tag counter
   // ****************************************************************
   // The external tag clock is a pin, so it is synchronised before use.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ext_s1_ff <= 1'b0;
         ext_s2_ff <= 1'b0;
         ext_s3_ff <= 1'b0;
      end else begin
         ext_s1_ff <= i_tag_ext_clk;
         ext_s2_ff <= ext_s1_ff;
         ext_s3_ff <= ext_s2_ff;
      end
   end
   assign ext_rise = ext_s2_ff && !ext_s3_ff;

   // Codes 0..5 give 2..64 us per count; 6 selects the external clock and
   // 7 stops the counter, an encoding choice of this design.
   assign tag_res = cfg_sec_ff[`CS_TTR_HI:`CS_TTR_LO];
   always @* begin
      tag_span = 6'd0;
      case (tag_res)
         3'd0: tag_span = 6'd0;
         3'd1: tag_span = 6'd1;
         3'd2: tag_span = 6'd3;
         3'd3: tag_span = 6'd7;
         3'd4: tag_span = 6'd15;
         3'd5: tag_span = 6'd31;
         default: tag_span = 6'd0;
      endcase
   end
   assign tag_tick = (tag_res == 3'd6) ? ext_rise :
                     (tag_res == 3'd7) ? 1'b0 :
                     (base_tick && tag_pre_ff == tag_span);

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         tag_pre_ff <= 6'd0;
         tag_ff     <= 16'h0000;
      end else begin
         if (base_tick) begin
            tag_pre_ff <= (tag_pre_ff >= tag_span) ? 6'd0 : tag_pre_ff + 6'd1;
         end
         if (i_sync_data && cfg_sec_ff[`CS_SYNC_LOAD]) begin
            tag_ff <= i_sync_word;
         end else if (i_sync && cfg_sec_ff[`CS_SYNC_CLR]) begin
            tag_ff <= 16'h0000;
         end else if (tag_tick) begin
            tag_ff <= tag_ff + 16'h0001;
         end
      end
   end
   assign o_time_tag = tag_ff;

   // ****************************************************************
   // Decoded controls for the engine
   // ****************************************************************
   // Alternate status reverses the area bit sense.
   assign o_area_b         = (is_rt && i_alt_status_en) ? !cfg_pri_ff[`CP_AREA]
                                                        : cfg_pri_ff[`CP_AREA];
   assign o_msg_monitor_en = !is_bc && cfg_pri_ff[`CP_MMT];
   assign o_status_flags   = (is_rt && !i_alt_status_en) ? cfg_pri_ff[11:7] : 5'b00000;
   assign o_alt_status     = (is_rt && i_alt_status_en) ? cfg_pri_ff[11:1] : 11'h000;
   assign o_bc_controls    = is_bc ? cfg_pri_ff[11:0] & 12'hFF8 : 12'h000;
   assign o_int_enable     = int_mask_ff[14:0];
   assign o_cfg_secondary  = cfg_sec_ff;

   // ****************************************************************
   // Read mux
   // ****************************************************************
   // Live read-only indications replace the low bits of the primary config.
   always @* begin
      ro_bits = 16'h0000;
      if (is_bc) begin
         ro_bits[2:0] = {i_eng_enabled, i_frame_active, i_msg_active};
      end else if (is_mt) begin
         ro_bits[2:0] = {i_eng_enabled, o_mon_triggered, o_mon_active};
      end else begin
         ro_bits[0] = i_msg_active;
      end
   end

   // Data is registered; unmapped offsets read as zero.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         if (i_addr == `OFF_INT_MASK) begin
            o_rdata <= int_mask_ff;
         end else if (i_addr == `OFF_CFG_PRI) begin
            o_rdata <= cfg_pri_ff | ro_bits;
         end else if (i_addr == `OFF_CFG_SEC) begin
            o_rdata <= cfg_sec_ff;
         end else if (i_addr == `OFF_DATA_STACK) begin
            o_rdata <= stack_ptr_ff;
         end else if (i_addr == `OFF_FRAME_LEFT) begin
            o_rdata <= frame_left_ff;
         end else if (i_addr == `OFF_MSG_LEFT) begin
            o_rdata <= msg_left_ff;
         end else if (i_addr == `OFF_FRAME_SHARED) begin
            o_rdata <= shared_ff;
         end else if (i_addr == `OFF_STATUS_WORD) begin
            o_rdata <= i_status_word;
         end else if (i_addr == `OFF_BIT_WORD) begin
            o_rdata <= i_bit_word;
         end else begin
            o_rdata <= 16'h0000;
         end
      end
   end
endmodule // bus_terminal_host_registers

/* sim/bus_terminal_host_registers_checker.sv */
// Concurrent checks on the ports of the host register bank.
`timescale 1ns/1ps
`include "bus_terminal_host_map.vh"
module bus_terminal_host_registers_checker (
   input wire logic        i_clk,
   input wire logic        i_rst_n,
   input wire logic [4:0]  i_addr,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   input wire logic        i_alt_status_en,
   input wire logic        i_eng_enabled,
   input wire logic        i_frame_active,
   input wire logic        i_msg_active,
   input wire logic        i_frame_start,
   input wire logic [15:0] i_status_word,
   input wire logic [15:0] i_bit_word,
   input wire logic [1:0]  o_role,
   input wire logic        o_frame_done,
   input wire logic [10:0] o_alt_status,
   input wire logic [14:0] o_int_enable,
   input wire logic [15:0] o_cfg_secondary
);
   // A read is taken at the strobed edge and its word shows one cycle later.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_rst_n);
   // A lone read strobe; a same-cycle write would blur the readback.
   wire rd_ok = i_rd && !i_wr;
   a_mask_bit_reserved: assert property (rd_ok && i_addr == `OFF_INT_MASK |=>
      o_rdata == {1'b0, $past(o_int_enable)}) else $error("mask readback wrong");
   a_cfg2_readback: assert property (rd_ok && i_addr == `OFF_CFG_SEC |=>
      o_rdata == $past(o_cfg_secondary)) else $error("cfg2 readback wrong");
   a_role_readback: assert property (rd_ok && i_addr == `OFF_CFG_PRI |=>
      o_rdata[15:14] == $past(o_role)) else $error("role readback wrong");
   a_bc_state_bits: assert property (rd_ok && i_addr == `OFF_CFG_PRI &&
      o_role == `ROLE_BC |=> o_rdata[2] == $past(i_eng_enabled) &&
      o_rdata[1] == $past(i_frame_active) && o_rdata[0] == $past(i_msg_active))
      else $error("bc state bits wrong");
   a_alt_status_map: assert property (rd_ok && i_addr == `OFF_CFG_PRI &&
      o_role == `ROLE_RT && i_alt_status_en |=> o_rdata[11:1] == $past(o_alt_status))
      else $error("alt status bits wrong");
   a_status_word_ro: assert property (rd_ok && i_addr == `OFF_STATUS_WORD |=>
      o_rdata == $past(i_status_word)) else $error("status word wrong");
   a_bit_word_ro: assert property (rd_ok && i_addr == `OFF_BIT_WORD |=>
      o_rdata == $past(i_bit_word)) else $error("test word wrong");
   a_frame_done_level: assert property (rd_ok && i_addr == `OFF_FRAME_LEFT &&
      o_role == `ROLE_BC && !i_frame_start |=> $past(o_frame_done) ==
      (o_rdata == 16'h0000 && $past(i_frame_active))) else $error("frame done level wrong");
endmodule // bus_terminal_host_registers_checker
bind bus_terminal_host_registers bus_terminal_host_registers_checker u_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_alt_status_en(i_alt_status_en), .i_eng_enabled(i_eng_enabled),
   .i_frame_active(i_frame_active), .i_msg_active(i_msg_active),
   .i_frame_start(i_frame_start), .i_status_word(i_status_word), .i_bit_word(i_bit_word),
   .o_role(o_role), .o_frame_done(o_frame_done), .o_alt_status(o_alt_status),
   .o_int_enable(o_int_enable), .o_cfg_secondary(o_cfg_secondary)
);

/* sim/host_port_model.sv */
// Host processor model issuing single-word accesses on the register port.
`timescale 1ns/1ps
module host_port_model (
   input  wire logic        i_clk,
   input  wire logic [15:0] i_rdata,
   output logic      [4:0]  o_addr,
   output logic             o_wr,
   output logic             o_rd,
   output logic      [15:0] o_wdata
);
   // Released lines show inverted values so stale data never looks valid.
   initial begin
      o_addr = 5'h1F;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 16'h0000;
   end
   // Strobes change at the falling edge so the rising edge sees settled lines.
   task automatic reg_wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = v;
      o_wr = 1'b1;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~v;
   endtask
   // The word is registered at the read edge and taken half a cycle later.
   task automatic reg_rd(input logic [4:0] a, output logic [15:0] v);
      @(negedge i_clk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      v = i_rdata;
   endtask
endmodule // host_port_model

/* sim/bus_terminal_host_registers_tb.sv */
// Self-checking bench for the host register bank.
`timescale 1ns/1ps
`include "bus_terminal_host_map.vh"
module bus_terminal_host_registers_tb;
   logic i_clk = 1'b0, i_rst_n = 1'b0, i_alt_status_en = 1'b0, i_eng_enabled = 1'b0;
   logic i_frame_active = 1'b1, i_msg_active = 1'b0, i_frame_start = 1'b0, i_sync = 1'b0;
   logic i_msg_gap_load = 1'b0, i_cmd_valid = 1'b0, i_stack_store = 1'b0;
   logic i_stack_load = 1'b0, i_sync_data = 1'b0, i_mon_word_valid = 1'b0;
   logic i_tag_ext_clk = 1'b0, i_wr, i_rd;
   logic [4:0]  i_addr;
   logic [15:0] i_wdata, d, i_msg_gap_us = 16'h0000, i_cmd_word = 16'h0000;
   logic [15:0] i_stack_base = 16'h0000, i_status_word = 16'hC3C3, i_bit_word = 16'h3C3C;
   logic [15:0] i_sync_word = 16'h0000, i_mon_word = 16'h0000;
   logic [15:0] cfg2_pat [4] = '{16'hFFFF, 16'hA5A5, 16'h5A5A, 16'h0000};
   wire  [15:0] o_rdata, o_time_tag, o_cfg_secondary;
   wire  [14:0] o_int_enable;
   wire  [11:0] o_bc_controls;
   wire  [10:0] o_alt_status;
   wire  [4:0]  o_status_flags;
   wire  [1:0]  o_role;
   wire o_frame_done, o_msg_due, o_mon_triggered, o_mon_active, o_trigger_event;
   wire o_area_b, o_msg_monitor_en;
   int errors = 0;
   int comparisons = 0;
   host_port_model u_host (.i_clk(i_clk), .i_rdata(o_rdata), .o_addr(i_addr), .o_wr(i_wr),
      .o_rd(i_rd), .o_wdata(i_wdata));
   bus_terminal_host_registers dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata),
      .i_alt_status_en(i_alt_status_en), .i_eng_enabled(i_eng_enabled),
      .i_frame_active(i_frame_active), .i_msg_active(i_msg_active),
      .i_frame_start(i_frame_start), .i_msg_gap_load(i_msg_gap_load),
      .i_msg_gap_us(i_msg_gap_us), .i_cmd_valid(i_cmd_valid), .i_cmd_word(i_cmd_word),
      .i_stack_store(i_stack_store), .i_stack_load(i_stack_load),
      .i_stack_base(i_stack_base), .i_status_word(i_status_word), .i_bit_word(i_bit_word),
      .i_sync(i_sync), .i_sync_data(i_sync_data), .i_sync_word(i_sync_word),
      .i_mon_word_valid(i_mon_word_valid), .i_mon_word(i_mon_word),
      .i_tag_ext_clk(i_tag_ext_clk), .o_role(o_role), .o_frame_done(o_frame_done),
      .o_msg_due(o_msg_due), .o_mon_triggered(o_mon_triggered), .o_mon_active(o_mon_active),
      .o_trigger_event(o_trigger_event), .o_time_tag(o_time_tag),
      .o_status_flags(o_status_flags), .o_alt_status(o_alt_status), .o_area_b(o_area_b),
      .o_msg_monitor_en(o_msg_monitor_en), .o_int_enable(o_int_enable),
      .o_cfg_secondary(o_cfg_secondary), .o_bc_controls(o_bc_controls));
   // Free-running 100 MHz clock.
   always #5 i_clk = ~i_clk;
   // Word compare; case inequality so an unknown never passes.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t: word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [4:0] a, input logic [15:0] exp);
      u_host.reg_rd(a, d);
      chk(d, exp);
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] v);
      u_host.reg_wr(a, v);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // One monitored word; the combinational trigger pulse is seen mid-cycle.
   task automatic mon_word(input logic [15:0] w, input logic hit, input logic act);
      @(negedge i_clk);
      i_mon_word = w;
      i_mon_word_valid = 1'b1;
      #1 chk({15'h0000, o_trigger_event}, {15'h0000, hit});
      @(negedge i_clk);
      i_mon_word_valid = 1'b0;
      chk({14'h0000, o_mon_triggered, o_mon_active}, {14'h0000, hit, act});
   endtask
   task automatic wrap_up;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Main sequence: reset, register map, roles, monitor, timers, time tag.
   initial begin
      cyc(4);
      i_rst_n = 1'b1;
      i_eng_enabled = 1'b1;
      i_msg_active = 1'b1;
      rc(`OFF_INT_MASK, `RST_INT_MASK);
      rc(`OFF_CFG_PRI, 16'h0007);
      rc(`OFF_CFG_SEC, `RST_CFG_SEC);
      wr(`OFF_INT_MASK, 16'hFFFF);
      rc(`OFF_INT_MASK, 16'h7FFF);
      wr(`OFF_INT_MASK, 16'h0002);
      chk({1'b0, o_int_enable}, 16'h0002);
      foreach (cfg2_pat[i]) begin
         wr(`OFF_CFG_SEC, cfg2_pat[i]);
         rc(`OFF_CFG_SEC, cfg2_pat[i]);
      end
      wr(`OFF_CFG_PRI, 16'h3FFF);
      rc(`OFF_CFG_PRI, 16'h3FFF);
      chk({4'h0, o_bc_controls}, 16'h0FF8);
      wr(`OFF_CFG_PRI, 16'h9F86);
      rc(`OFF_CFG_PRI, 16'h9F81);
      chk({9'h000, o_status_flags, o_msg_monitor_en, o_area_b}, 16'h007E);
      i_alt_status_en = 1'b1;
      wr(`OFF_CFG_PRI, 16'hAAAA);
      rc(`OFF_CFG_PRI, 16'hAAAB);
      chk({4'h0, o_alt_status, o_area_b}, 16'h0AAA);
      i_cmd_word = 16'h1234;
      @(negedge i_clk) i_cmd_valid = 1'b1;
      @(negedge i_clk) i_cmd_valid = 1'b0;
      rc(`OFF_FRAME_SHARED, 16'h1234);
      wr(`OFF_STATUS_WORD, 16'hFFFF);
      wr(`OFF_BIT_WORD, 16'h0000);
      rc(`OFF_STATUS_WORD, 16'hC3C3);
      rc(`OFF_BIT_WORD, 16'h3C3C);
      wr(5'h18, 16'hFFFF);
      rc(5'h18, 16'h0000);
      i_alt_status_en = 1'b0;
      wr(`OFF_CFG_PRI, 16'h5C00);
      wr(`OFF_FRAME_SHARED, 16'hABCD);
      rc(`OFF_FRAME_SHARED, 16'hABCD);
      i_stack_base = 16'h0100;
      @(negedge i_clk) i_stack_load = 1'b1;
      @(negedge i_clk) i_stack_load = 1'b0;
      rc(`OFF_DATA_STACK, 16'h0100);
      mon_word(16'h1111, 1'b0, 1'b0);
      mon_word(16'hABCD, 1'b1, 1'b1);
      repeat (2) begin
         @(negedge i_clk) i_stack_store = 1'b1;
         @(negedge i_clk) i_stack_store = 1'b0;
      end
      rc(`OFF_DATA_STACK, 16'h0102);
      wr(`OFF_CFG_PRI, 16'h5E00);
      mon_word(16'hABCD, 1'b1, 1'b0);
      wr(`OFF_CFG_PRI, 16'h0000);
      wr(`OFF_FRAME_SHARED, 16'h0002);
      rc(`OFF_FRAME_SHARED, 16'h0002);
      @(negedge i_clk) i_frame_start = 1'b1;
      @(negedge i_clk) i_frame_start = 1'b0;
      cyc(5000);
      wr(`OFF_FRAME_LEFT, 16'hFFFF);
      rc(`OFF_FRAME_LEFT, 16'h0002);
      cyc(10000);
      rc(`OFF_FRAME_LEFT, 16'h0001);
      cyc(10000);
      rc(`OFF_FRAME_LEFT, 16'h0000);
      i_msg_gap_us = 16'h0032;
      @(negedge i_clk) i_msg_gap_load = 1'b1;
      @(negedge i_clk) i_msg_gap_load = 1'b0;
      cyc(2550);
      rc(`OFF_MSG_LEFT, 16'h0019);
      wr(`OFF_MSG_LEFT, 16'hFFFF);
      cyc(2600);
      rc(`OFF_MSG_LEFT, 16'h0000);
      chk({14'h0000, o_msg_due, o_frame_done}, 16'h0003);
      wr(`OFF_CFG_SEC, 16'h0320);
      i_sync_word = 16'h0040;
      @(negedge i_clk) i_sync_data = 1'b1;
      @(negedge i_clk) i_sync_data = 1'b0;
      chk(o_time_tag, 16'h0040);
      repeat (6) begin
         @(negedge i_clk) i_tag_ext_clk = ~i_tag_ext_clk;
         cyc(3);
      end
      chk(o_time_tag, 16'h0043);
      wr(`OFF_CFG_SEC, 16'h0340);
      @(negedge i_clk) i_sync = 1'b1;
      @(negedge i_clk) i_sync = 1'b0;
      chk(o_time_tag, 16'h0000);
      wr(`OFF_CFG_SEC, 16'h0080);
      cyc(2000);
      chk(o_time_tag, 16'h0005);
      wrap_up();
   end
   // Watchdog: the sequence needs about 32300 cycles.
   initial begin
      #600_000;
      errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      wrap_up();
   end
endmodule // bus_terminal_host_registers_tb
